// File: src/ovml_pkg.sv
// ============================================================================
// Shared constants of the output volume, mixer and limiter stage.
package ovml_pkg;

	localparam int          SAMPLE_W        = 24;

	// ========================================================================
	// Register offsets.
	localparam logic [7:0]  ADDR_GAIN_A     = 8'h16;
	localparam logic [7:0]  ADDR_GAIN_B     = 8'h17;
	localparam logic [7:0]  ADDR_ROUTE      = 8'h18;
	localparam logic [7:0]  ADDR_THRESH     = 8'h19;
	localparam logic [7:0]  ADDR_RELEASE    = 8'h1a;
	localparam logic [7:0]  ADDR_ATTACK     = 8'h1b;
	localparam logic [7:0]  ADDR_STATUS     = 8'h20;

	// ========================================================================
	// Field positions.
	localparam int          ROUTE_A_LSB     = 6;
	localparam int          ROUTE_B_LSB     = 4;
	localparam int          CEIL_LSB        = 5;
	localparam int          HYSTERESIS_LEVEL_LSB        = 2;
	localparam int          RAMP_OVR_BIT    = 1;
	localparam int          XING_OVR_BIT    = 0;
	localparam int          LIM_EN_BIT      = 7;
	localparam int          LIM_ALL_BIT     = 6;
	localparam int          ST_CLK_BIT      = 6;
	localparam int          ST_PROC_A_BIT   = 5;
	localparam int          ST_PROC_B_BIT   = 4;
	localparam int          ST_MIX_A_BIT    = 3;
	localparam int          ST_MIX_B_BIT    = 2;

	// ========================================================================
	// Reset values.
	localparam logic [7:0]  RST_GAIN        = 8'h00;
	localparam logic [7:0]  RST_ROUTE       = 8'h00;
	localparam logic [7:0]  RST_THRESH      = 8'h00;
	localparam logic [7:0]  RST_RELEASE     = 8'h7f;
	localparam logic [7:0]  RST_ATTACK      = 8'h00;
	localparam logic [7:0]  RST_STATUS      = 8'h40;

	// ========================================================================
	// Gain codes in half-dB units, limiter steps and thresholds.
	localparam logic [1:0]         DATA_SEL_ACTIVE = 2'h1;
	localparam logic [7:0]         GAIN_TOP_CODE   = 8'h18;
	localparam logic [7:0]         MUTE_CODE_LO    = 8'h19;
	localparam logic [7:0]         MUTE_CODE_HI    = 8'h34;
	localparam logic signed [8:0]  GAIN_MAX_HD     = 9'sh018;
	localparam logic signed [8:0]  MUTE_HD         = 9'sh134;
	localparam logic [7:0]         LIM_FAST_STEP   = 8'h06;
	localparam logic [7:0]         LIM_ATTEN_MAX   = 8'he4;
	localparam logic [23:0]        LIM_LEVEL [8]   = '{24'h7fffff, 24'h5a9df7, 24'h4026fe,
		24'h2d6a62, 24'h2026f7, 24'h101d51, 24'h08138a, 24'h040c37};

	typedef enum logic [1:0]
	{
		LIM_IDLE    = 2'b00,
		LIM_ATTACK  = 2'b01,
		LIM_HOLD    = 2'b11,
		LIM_RELEASE = 2'b10
	} ovml_lim_state_t;

endpackage

// File: src/ovml_gain_stage.sv
`timescale 1ns/1ns
`default_nettype none
module ovml_gain_stage
#(
	parameter int W = ovml_pkg::SAMPLE_W
)
(
	input  wire logic signed [W-1:0] i_sample,
	input  wire logic signed [8:0]   i_gain_hd,
	output logic signed [W-1:0]      o_sample,
	output logic                     o_overflow
);
	import ovml_pkg::*;

	// ========================================================================
	// Half-dB steps within one octave. Twelve steps make 6 dB, not the 6.02 dB of an octave, so
	// the gain drifts by a few hundredths of a dB per octave.
	localparam logic [16:0] STEP_GAIN [12] = '{17'h10000, 17'h0f1ae, 17'h0e429,
		17'h0d766, 17'h0cb59, 17'h0bff9, 17'h0b53c, 17'h0ab19, 17'h0a186,
		17'h0987d, 17'h08ff5, 17'h087e8};

	logic [8:0]           atten_hd;
	logic [4:0]           octave;
	logic [3:0]           frac;
	logic [18:0]          lin;
	logic signed [W+19:0] prod;
	logic signed [W+3:0]  scaled;

	always_comb
	begin
		atten_hd = 9'(GAIN_MAX_HD - i_gain_hd);
		octave = 5'(atten_hd / 9'd12);
		frac = 4'(atten_hd % 9'd12);
		lin = 19'({STEP_GAIN[frac], 2'b00} >> octave);
		if (i_gain_hd <= MUTE_HD)
		begin
			lin = '0;
		end
		prod = i_sample * $signed({1'b0, lin});
		scaled = (W+4)'(prod >>> 16);
		o_overflow = (scaled[W+3:W-1] != '0) && (scaled[W+3:W-1] != '1);
		if (o_overflow)
		begin
			o_sample = scaled[W+3] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
		end
		else
		begin
			o_sample = scaled[W-1:0];
		end
	end

endmodule // ovml_gain_stage
`default_nettype wire

// File: src/ovml_sticky_flag.sv
`timescale 1ns/1ns
`default_nettype none
module ovml_sticky_flag
#(
	parameter logic RESET_VAL = 1'b0
)
(
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	input  wire logic i_set,
	input  wire logic i_clear,
	output logic      o_flag
);
	logic flag_reg;
	logic flag_next;

	// A set in the clearing cycle wins, so no event slips past a read.
	always_comb
	begin
		flag_next = i_set | (flag_reg & ~i_clear);
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			flag_reg <= RESET_VAL;
		end
		else
		begin
			flag_reg <= flag_next;
		end
	end

	assign o_flag = flag_reg;

endmodule // ovml_sticky_flag
`default_nettype wire

// File: src/ovml_output_stage.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Per-channel 8-bit gain, 0.5 dB steps.
// - Gain code decode, mute band to -102 dB.
// - Gain changes follow soft ramp/zero cross.
// - Functions active only with data select 01.
// - Limiter drives gain automatically when enabled.
// - Output routing: left, right, or mono mix.
// - Ceiling code selects threshold below full scale.
// - Above ceiling, attenuate at attack rate.
// - Cushion threshold gives release hysteresis.
// - Ramp override, ignored under zero cross.
// - Crossing override skips zero-cross wait.
// - Enable bit turns limiting by attenuation on.
// - Limit-all bit couples both channels.
// - Release speed code, slowest by default.
// - Attack speed code, fastest by default.
// - Rates count samples, follow transition style.
// - Status flags sticky, cleared by a read of the status register.
// - Clock error flag on bad ratio.
// - Clock error reads one after reset.
// - Per-channel processing overflow flags.
// - Per-channel mix overflow flags.
module ovml_output_stage
(
	input  wire logic                                i_clk_sys,
	input  wire logic                                i_rst,
	input  wire logic                                i_reg_wr,
	input  wire logic                                i_reg_rd,
	input  wire logic [7:0]                          i_reg_addr,
	input  wire logic [7:0]                          i_reg_wdata,
	output logic [7:0]                               o_reg_rdata,
	output logic                                     o_reg_rvalid,
	input  wire logic [1:0]                          i_data_sel,
	input  wire logic [1:0]                          i_transition_style,
	input  wire logic                                i_ratio_invalid,
	input  wire logic                                i_mix_overflow_a,
	input  wire logic                                i_mix_overflow_b,
	input  wire logic                                i_sample_valid,
	input  wire logic signed [ovml_pkg::SAMPLE_W-1:0] i_sample_l,
	input  wire logic signed [ovml_pkg::SAMPLE_W-1:0] i_sample_r,
	output logic                                     o_sample_valid,
	output logic signed [ovml_pkg::SAMPLE_W-1:0]      o_sample_a,
	output logic signed [ovml_pkg::SAMPLE_W-1:0]      o_sample_b,
	output logic                                     o_limiter_active
);
	import ovml_pkg::*;

	// ========================================================================
	// Declarations.
	logic [7:0]                 gain_reg [2];
	logic [7:0]                 gain_next [2];
	logic [7:0]                 route_reg;
	logic [7:0]                 route_next;
	logic [7:0]                 thresh_reg;
	logic [7:0]                 thresh_next;
	logic [7:0]                 release_reg;
	logic [7:0]                 release_next;
	logic [7:0]                 attack_reg;
	logic [7:0]                 attack_next;
	logic [7:0]                 rdata_next;
	logic                       rd_status;
	logic [7:0]                 status_set;
	wire  [7:0]                 status_flags;
	logic                       proc_active;
	logic                       sample_go;
	logic                       lim_en;
	logic                       lim_zc;
	logic                       lim_sr;
	logic [7:0]                 lim_step;
	logic signed [SAMPLE_W:0]   mono_sum;
	logic signed [SAMPLE_W-1:0] mono;
	logic signed [SAMPLE_W-1:0] routed [2];
	logic signed [SAMPLE_W-1:0] gained [2];
	logic [1:0]                 gain_ovf;
	logic [SAMPLE_W-1:0]        mag [2];
	logic signed [8:0]          target_hd [2];
	logic signed [9:0]          diff_hd [2];
	logic signed [8:0]          eff_hd [2];
	logic [1:0]                 xing;
	logic [1:0]                 over;
	logic [1:0]                 quiet;
	logic [1:0]                 trig;
	logic [1:0]                 calm;
	logic signed [8:0]          vol_reg [2];
	logic signed [8:0]          vol_next [2];
	logic [7:0]                 atten_reg [2];
	logic [7:0]                 atten_next [2];
	logic [5:0]                 cnt_reg [2];
	logic [5:0]                 cnt_next [2];
	ovml_lim_state_t            lim_reg [2];
	ovml_lim_state_t            lim_next [2];
	logic [1:0]                 sign_reg;
	logic [1:0]                 sign_next;
	logic signed [SAMPLE_W-1:0] out_next [2];
	logic                       active_next;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	// ========================================================================
	// Register file.
	always_comb
	begin
		gain_next = gain_reg;
		route_next = route_reg;
		thresh_next = thresh_reg;
		release_next = release_reg;
		attack_next = attack_reg;
		if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				ADDR_GAIN_A:  gain_next[0] = i_reg_wdata;
				ADDR_GAIN_B:  gain_next[1] = i_reg_wdata;
				ADDR_ROUTE:   route_next = {i_reg_wdata[7:4], 4'h0};
				ADDR_THRESH:  thresh_next = i_reg_wdata;
				ADDR_RELEASE: release_next = i_reg_wdata;
				ADDR_ATTACK:  attack_next = {2'h0, i_reg_wdata[5:0]};
				default:      ;
			endcase
		end
		rd_status = i_reg_rd && (i_reg_addr == ADDR_STATUS);
		unique case (i_reg_addr)
			ADDR_GAIN_A:  rdata_next = gain_reg[0];
			ADDR_GAIN_B:  rdata_next = gain_reg[1];
			ADDR_ROUTE:   rdata_next = route_reg;
			ADDR_THRESH:  rdata_next = thresh_reg;
			ADDR_RELEASE: rdata_next = release_reg;
			ADDR_ATTACK:  rdata_next = attack_reg;
			ADDR_STATUS:  rdata_next = status_flags;
			default:      rdata_next = 8'h00;
		endcase
		if (!i_reg_rd)
		begin
			rdata_next = o_reg_rdata;
		end
	end

	// ========================================================================
	// Sticky status flags; the clock error flag comes out of reset set.
	always_comb
	begin
		status_set = 8'h00;
		status_set[ST_CLK_BIT] = i_ratio_invalid;
		status_set[ST_PROC_A_BIT] = sample_go & gain_ovf[0];
		status_set[ST_PROC_B_BIT] = sample_go & gain_ovf[1];
		status_set[ST_MIX_A_BIT] = i_mix_overflow_a;
		status_set[ST_MIX_B_BIT] = i_mix_overflow_b;
	end

	for (genvar b = ST_MIX_B_BIT; b <= ST_CLK_BIT; b++)
	begin : g_flag
		ovml_sticky_flag #(
			.RESET_VAL (RST_STATUS[b])
		) u_flag (
			.i_clk_sys (i_clk_sys),
			.i_rst     (i_rst),
			.i_set     (status_set[b]),
			.i_clear   (rd_status),
			.o_flag    (status_flags[b])
		);
	end

	assign status_flags[7] = 1'b0;
	assign status_flags[1:0] = 2'h0;

	// ========================================================================
	// Routing, gain decode and level detection.
	always_comb
	begin
		proc_active = (i_data_sel == DATA_SEL_ACTIVE);
		sample_go = i_sample_valid & proc_active;
		lim_en = release_reg[LIM_EN_BIT];
		lim_zc = i_transition_style[0] & ~thresh_reg[XING_OVR_BIT];
		lim_sr = i_transition_style[1] & ~(thresh_reg[RAMP_OVR_BIT] & ~i_transition_style[0]);
		lim_step = lim_sr ? 8'h01 : LIM_FAST_STEP;
		mono_sum = {i_sample_l[SAMPLE_W-1], i_sample_l} + {i_sample_r[SAMPLE_W-1], i_sample_r};
		mono = mono_sum[SAMPLE_W:1];
		unique case (route_reg[ROUTE_A_LSB +: 2])
			2'h0:       routed[0] = i_sample_l;
			2'h1, 2'h2: routed[0] = mono;
			2'h3:       routed[0] = i_sample_r;
		endcase
		unique case (route_reg[ROUTE_B_LSB +: 2])
			2'h0:       routed[1] = i_sample_r;
			2'h1, 2'h2: routed[1] = mono;
			2'h3:       routed[1] = i_sample_l;
		endcase
		for (int ch = 0; ch < 2; ch++)
		begin
			target_hd[ch] = ((gain_reg[ch] >= MUTE_CODE_LO) && (gain_reg[ch] <= MUTE_CODE_HI))
				? MUTE_HD : $signed({gain_reg[ch] > GAIN_TOP_CODE, gain_reg[ch]});
			diff_hd[ch] = $signed({vol_reg[ch][8], vol_reg[ch]})
				- $signed({2'h0, atten_reg[ch]});
			eff_hd[ch] = (diff_hd[ch] < $signed({MUTE_HD[8], MUTE_HD})) ? MUTE_HD
				: diff_hd[ch][8:0];
			mag[ch] = gained[ch][SAMPLE_W-1] ? SAMPLE_W'(-gained[ch]) : SAMPLE_W'(gained[ch]);
			over[ch] = (mag[ch] > LIM_LEVEL[thresh_reg[CEIL_LSB +: 3]]) || gain_ovf[ch];
			quiet[ch] = (mag[ch] < LIM_LEVEL[thresh_reg[CEIL_LSB +: 3]])
				&& (mag[ch] < LIM_LEVEL[thresh_reg[HYSTERESIS_LEVEL_LSB +: 3]]);
			xing[ch] = (routed[ch] == '0) || (routed[ch][SAMPLE_W-1] != sign_reg[ch]);
		end
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_chan
		ovml_gain_stage #(
			.W (SAMPLE_W)
		) u_gain (
			.i_sample   (routed[g]),
			.i_gain_hd  (eff_hd[g]),
			.o_sample   (gained[g]),
			.o_overflow (gain_ovf[g])
		);
	end

	// ========================================================================
	// Volume ramp and limiter. Rates count samples, so they track the sample
	// rate. Zero-cross pacing can stall on a DC signal; that is accepted.
	always_comb
	begin
		ovml_lim_state_t ph;
		logic [5:0]      base;
		logic [5:0]      rate;
		ph = LIM_IDLE;
		base = 6'h00;
		rate = 6'h00;
		for (int ch = 0; ch < 2; ch++)
		begin
			trig[ch] = release_reg[LIM_ALL_BIT] ? (|over) : over[ch];
			calm[ch] = release_reg[LIM_ALL_BIT] ? (&quiet) : quiet[ch];
		end
		for (int ch = 0; ch < 2; ch++)
		begin
			vol_next[ch] = vol_reg[ch];
			atten_next[ch] = atten_reg[ch];
			cnt_next[ch] = cnt_reg[ch];
			lim_next[ch] = lim_reg[ch];
			if (!lim_en)
			begin
				atten_next[ch] = 8'h00;
				cnt_next[ch] = 6'h00;
				lim_next[ch] = LIM_IDLE;
			end
			else if (sample_go)
			begin
				if (trig[ch])
				begin
					ph = LIM_ATTACK;
				end
				else if (calm[ch])
				begin
					ph = (atten_reg[ch] == 8'h00) ? LIM_IDLE : LIM_RELEASE;
				end
				else
				begin
					ph = (atten_reg[ch] == 8'h00) ? LIM_IDLE : LIM_HOLD;
				end
				base = (ph == lim_reg[ch]) ? cnt_reg[ch] : 6'h00;
				rate = (ph == LIM_ATTACK) ? attack_reg[5:0] : release_reg[5:0];
				lim_next[ch] = ph;
				if (((ph == LIM_ATTACK) || (ph == LIM_RELEASE)) && (base >= rate)
					&& (!lim_zc || xing[ch]))
				begin
					cnt_next[ch] = 6'h00;
					if (ph == LIM_ATTACK)
					begin
						atten_next[ch] = (atten_reg[ch] > LIM_ATTEN_MAX - lim_step)
							? LIM_ATTEN_MAX : atten_reg[ch] + lim_step;
					end
					else
					begin
						atten_next[ch] = (atten_reg[ch] > lim_step)
							? atten_reg[ch] - lim_step : 8'h00;
					end
				end
				else
				begin
					cnt_next[ch] = (base == 6'h3f) ? base : base + 6'h01;
				end
			end
			if (sample_go && (i_transition_style[0] == 1'b0 || xing[ch]))
			begin
				if (!i_transition_style[1])
				begin
					vol_next[ch] = target_hd[ch];
				end
				else if (vol_reg[ch] < target_hd[ch])
				begin
					vol_next[ch] = vol_reg[ch] + 9'sh001;
				end
				else if (vol_reg[ch] > target_hd[ch])
				begin
					vol_next[ch] = vol_reg[ch] - 9'sh001;
				end
			end
			out_next[ch] = i_sample_valid ? (proc_active ? gained[ch] : (ch == 0 ? i_sample_l
				: i_sample_r)) : (ch == 0 ? o_sample_a : o_sample_b);
			sign_next[ch] = i_sample_valid ? routed[ch][SAMPLE_W-1] : sign_reg[ch];
		end
		active_next = (lim_next[0] != LIM_IDLE) || (lim_next[1] != LIM_IDLE);
	end

	// ========================================================================
	// State registers.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			gain_reg <= '{RST_GAIN, RST_GAIN};
			route_reg <= RST_ROUTE;
			thresh_reg <= RST_THRESH;
			release_reg <= RST_RELEASE;
			attack_reg <= RST_ATTACK;
			o_reg_rdata <= 8'h00;
			o_reg_rvalid <= 1'b0;
			vol_reg <= '{9'sh000, 9'sh000};
			atten_reg <= '{8'h00, 8'h00};
			cnt_reg <= '{6'h00, 6'h00};
			lim_reg <= '{LIM_IDLE, LIM_IDLE};
			sign_reg <= 2'h0;
			o_sample_a <= '0;
			o_sample_b <= '0;
			o_sample_valid <= 1'b0;
			o_limiter_active <= 1'b0;
		end
		else
		begin
			gain_reg <= gain_next;
			route_reg <= route_next;
			thresh_reg <= thresh_next;
			release_reg <= release_next;
			attack_reg <= attack_next;
			o_reg_rdata <= rdata_next;
			o_reg_rvalid <= i_reg_rd;
			vol_reg <= vol_next;
			atten_reg <= atten_next;
			cnt_reg <= cnt_next;
			lim_reg <= lim_next;
			sign_reg <= sign_next;
			o_sample_a <= out_next[0];
			o_sample_b <= out_next[1];
			o_sample_valid <= i_sample_valid;
			o_limiter_active <= active_next;
		end
	end

	// ========================================================================
	// Assertions.
	sequence s_quiet_read;
		rd_status && (status_set == 8'h00);
	endsequence

	sequence s_attack_due;
		sample_go && lim_en && trig[0] && !lim_zc && (attack_reg[5:0] == 6'h00)
			&& (atten_reg[0] < LIM_ATTEN_MAX);
	endsequence

	sequence s_coupled_over;
		sample_go && lim_en && release_reg[LIM_ALL_BIT] && over[1] && !lim_zc
			&& (attack_reg[5:0] == 6'h00) && (atten_reg[0] < LIM_ATTEN_MAX);
	endsequence

	a_status_read_clear: assert property (s_quiet_read |=> (status_flags == 8'h00))
		else $error("Status flags survived a read.");
	a_clock_flag_set: assert property (i_ratio_invalid |=> status_flags[ST_CLK_BIT])
		else $error("Clock error flag missed a bad ratio.");
	a_clock_flag_boot: assert property ($past(i_rst) |-> status_flags[ST_CLK_BIT])
		else $error("Clock error flag low after reset.");
	a_gain_mute_band: assert property ((gain_reg[0] >= MUTE_CODE_LO)
		&& (gain_reg[0] <= MUTE_CODE_HI) |-> (target_hd[0] == MUTE_HD))
		else $error("Mute band code not decoded as mute.");
	a_bypass_path: assert property (i_sample_valid && !proc_active
		|=> (o_sample_a == $past(i_sample_l)) && (o_sample_b == $past(i_sample_r)))
		else $error("Inactive selector did not pass samples through.");
	a_mono_route: assert property (sample_go && (route_reg[ROUTE_A_LSB +: 2] == 2'h1)
		&& (eff_hd[0] == 9'sh000) |=> (o_sample_a == $past(mono)))
		else $error("Mono route did not average both channels.");
	a_limiter_off: assert property (!lim_en |=> (atten_reg[0] == 8'h00)
		&& (atten_reg[1] == 8'h00))
		else $error("Attenuation held while limiter disabled.");
	a_attack_step: assert property (s_attack_due |=> (atten_reg[0] > $past(atten_reg[0])))
		else $error("Attack did not raise attenuation.");
	a_coupled_limit: assert property (s_coupled_over |=> (atten_reg[0] > $past(atten_reg[0])))
		else $error("Coupled limiting ignored the other channel.");
	a_soft_ramp_step: assert property (sample_go && (i_transition_style == 2'h2)
		|=> (vol_reg[0] == $past(vol_reg[0])) || (vol_reg[0] == $past(vol_reg[0]) + 9'sh001)
		|| (vol_reg[0] == $past(vol_reg[0]) - 9'sh001))
		else $error("Soft ramp moved gain by more than one step.");
	a_overflow_flag: assert property (sample_go && gain_ovf[0]
		|=> status_flags[ST_PROC_A_BIT] && ((o_sample_a == {1'b0, {(SAMPLE_W-1){1'b1}}})
		|| (o_sample_a == {1'b1, {(SAMPLE_W-1){1'b0}}})))
		else $error("Overflow not saturated and flagged.");

endmodule // ovml_output_stage
`default_nettype wire

// File: verification/ovml_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Far-side source. A sample stands for one valid cycle only; the lines are
// inverted on every idle cycle so that nothing stale can pass for good data.
module ovml_src_model
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_go,
	input  wire logic [23:0] i_l,
	input  wire logic [23:0] i_r,
	output logic             o_valid = 1'b0,
	output logic [23:0]      o_l = 24'h000000,
	output logic [23:0]      o_r = 24'h000000
);
	always_ff @(posedge i_clk_sys)
	begin
		o_valid <= i_go;
		o_l     <= i_go ? i_l : ~o_l;
		o_r     <= i_go ? i_r : ~o_r;
	end
endmodule // ovml_src_model
`default_nettype wire

// File: verification/tb_ovml_output_stage.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Bench of the output stage.
module tb_ovml_output_stage;
	import ovml_pkg::*;
	logic        i_clk_sys = 1'b0;
	logic        i_rst = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        go = 1'b0;
	logic        rv, sv, v, act;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wd = 8'h00;
	logic [7:0]  rdata;
	logic [1:0]  dsel = 2'h1;
	logic [1:0]  sty = 2'h0;
	logic [2:0]  ev = 3'h0;
	logic [23:0] l = 24'h0;
	logic [23:0] r = 24'h0;
	logic [23:0] sl, sr, oa, ob, x, y;
	logic [7:0]  ra [8] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h20, 8'h21};
	logic [7:0]  re [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h00, 8'h40, 8'h00};
	int          mismatches = 0;
	int          checks_done = 0;

	always #50 i_clk_sys = ~i_clk_sys;

	ovml_src_model i_ovml_src_model
	(
		.i_clk_sys (i_clk_sys),
		.i_go      (go),
		.i_l       (l),
		.i_r       (r),
		.o_valid   (v),
		.o_l       (sl),
		.o_r       (sr)
	);

	ovml_output_stage i_ovml_output_stage
	(
		.i_clk_sys          (i_clk_sys),
		.i_rst              (i_rst),
		.i_reg_wr           (wr),
		.i_reg_rd           (rd),
		.i_reg_addr         (addr),
		.i_reg_wdata        (wd),
		.o_reg_rdata        (rdata),
		.o_reg_rvalid       (rv),
		.i_data_sel         (dsel),
		.i_transition_style (sty),
		.i_ratio_invalid    (ev[2]),
		.i_mix_overflow_a   (ev[1]),
		.i_mix_overflow_b   (ev[0]),
		.i_sample_valid     (v),
		.i_sample_l         (sl),
		.i_sample_r         (sr),
		.o_sample_valid     (sv),
		.o_sample_a         (oa),
		.o_sample_b         (ob),
		.o_limiter_active   (act)
	);

	// ========================================================================
	// Shared tasks.
	task automatic complete_run();
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge i_clk_sys);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge i_clk_sys);
		rd <= 1'b0;
		#1;
		chk({23'h0, rv}, 24'h1);
		chk({16'h0, rdata}, {16'h0, e});
	endtask

	task automatic evt(input logic [2:0] e, input logic [7:0] s);
		@(posedge i_clk_sys);
		ev <= e;
		@(posedge i_clk_sys);
		ev <= 3'h0;
		rreg(ADDR_STATUS, s);
	endtask

	task automatic snd(input logic [23:0] a, input logic [23:0] b);
		@(posedge i_clk_sys);
		go <= 1'b1;
		l <= a;
		r <= b;
		@(posedge i_clk_sys);
		go <= 1'b0;
		@(posedge i_clk_sys);
		#1;
		chk({23'h0, sv}, 24'h1);
	endtask

	// The mono mix is exact only for an even sum, so the bench keeps sums even.
	function automatic logic [23:0] route(input logic [1:0] c, input bit a,
		input logic [23:0] p, input logic [23:0] q);
		logic signed [24:0] s;
		s = $signed({p[23], p}) + $signed({q[23], q});
		if (c == 2'h0)
			return a ? p : q;
		if (c == 2'h3)
			return a ? q : p;
		return s[24:1];
	endfunction

	// ========================================================================
	// Main sequence.
	initial
	begin
		void'($urandom(22845));
		repeat (12) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		for (int i = 0; i < 8; i++)
			rreg(ra[i], re[i]);
		rreg(ADDR_STATUS, 8'h00);
		evt(3'h4, 8'h40);
		evt(3'h2, 8'h08);
		evt(3'h1, 8'h04);
		wreg(ADDR_STATUS, 8'hff);
		rreg(ADDR_STATUS, 8'h00);
		wreg(ADDR_ROUTE, 8'hff);
		rreg(ADDR_ROUTE, 8'hf0);
		for (int i = 0; i < 16; i++)
		begin
			x = 24'($urandom());
			y = 24'($urandom());
			y[0] = x[0];
			wreg(ADDR_ROUTE, {i[3:0], 4'h0});
			snd(x, y);
			chk(oa, route(i[3:2], 1'b1, x, y));
			chk(ob, route(i[1:0], 1'b0, x, y));
		end
		@(posedge i_clk_sys);
		dsel <= 2'h0;
		snd(x, y);
		chk(oa, x);
		chk(ob, y);
		@(posedge i_clk_sys);
		dsel <= 2'h1;
		wreg(ADDR_ROUTE, 8'h00);
		wreg(ADDR_GAIN_A, 8'h18);
		wreg(ADDR_GAIN_B, 8'h19);
		snd(24'h0003e8, 24'h0003e8);
		snd(24'h0003e8, 24'h0003e8);
		chk(oa, 24'h000fa0);
		chk(ob, 24'h000000);
		wreg(ADDR_GAIN_B, 8'h34);
		snd(24'h0003e8, 24'h0003e8);
		chk(ob, 24'h000000);
		wreg(ADDR_GAIN_B, 8'h00);
		// A new gain applies from the sample after the one that takes it.
		repeat (2) snd(24'h400000, 24'h000100);
		chk(oa, 24'h7fffff);
		chk(ob, 24'h000100);
		snd(24'hc00000, 24'h000100);
		chk(oa, 24'h800000);
		rreg(ADDR_STATUS, 8'h20);
		// Slowest release keeps the attenuation from drifting back mid-check.
		wreg(ADDR_RELEASE, 8'hff);
		repeat (12) snd(24'h400000, 24'h000100);
		chk({23'h0, act}, 24'h1);
		chk({22'h0, oa < 24'h7fffff, ob < 24'h000100}, 24'h3);
		wreg(ADDR_RELEASE, 8'h3f);
		repeat (2) snd(24'h400000, 24'h000100);
		chk({23'h0, act}, 24'h0);
		chk(ob, 24'h000100);
		@(posedge i_clk_sys);
		sty <= 2'h2;
		wreg(ADDR_GAIN_B, 8'hf4);
		repeat (2) snd(24'h000100, 24'h000100);
		chk({23'h0, ob > 24'h000080 && ob < 24'h000100}, 24'h1);
		repeat (12) snd(24'h000100, 24'h000100);
		chk(ob, 24'h000080);
		@(posedge i_clk_sys);
		sty <= 2'h1;
		wreg(ADDR_GAIN_B, 8'h00);
		repeat (2) snd(24'h000100, 24'h000100);
		chk(ob, 24'h000080);
		snd(24'h000100, 24'h000000);
		snd(24'h000100, 24'h000100);
		chk(ob, 24'h000100);
		complete_run();
	end

	initial
	begin
		repeat (20000) @(posedge i_clk_sys);
		mismatches++;
		complete_run();
	end
endmodule // tb_ovml_output_stage
`default_nettype wire
